// >>> core/dos_top.sv
`timescale 1ns/1ps
// ****************************************
// Output sequencer for a multichannel converter
// ****************************************
// Behaviour
// RULE_01: Simple mode start loads every selected channel once, then ends the operation.
// RULE_02: Each channel holds for the settling time; settling sets the conversion pace.
// RULE_03: All output codes are sixteen bits wide, zero to full scale.
// RULE_04: Codes map linearly onto the range; the converter does that, codes pass unchanged.
// RULE_05: Range comes from board jumpers; no range setting exists here.
// RULE_06: Channels converted are a contiguous group from channel zero, sized by count.
// RULE_07: Clocked mode converts once per sampling clock between start and stop.
// RULE_08: Every conversion pass while sampling is counted; count is readable and stops runs.
// RULE_09: Software selects internal divider or external sampling clock as pacing source.
// RULE_10: With external clock, each detected rising edge starts one conversion pass.
// RULE_11: FIFO mode appends new codes and converts the oldest; writes allowed while running.
// RULE_12: FIFO write when full flags overflow but running output continues.
// RULE_13: Ring mode rejects writes while running and replays stored codes in order.
// RULE_14: Start and stop conditions are separate, independent control fields.
// RULE_15: Software start begins at once; trigger start waits for the chosen edge.
// RULE_16: Count stop ends sampling when count reaches the programmed value.
// RULE_17: Trigger stop is watched only while sampling, on the chosen edge.
// RULE_18: Any error forces sampling to stop whatever stop condition is set.
// RULE_19: Ring mode repeats runs the set count, or forever until software stop.
// RULE_20: Events for triggered start, stop when repeating, and end of operation.
// RULE_21: Count-complete event once per run in FIFO, once per repetition in ring.
// RULE_22: Sampling clock faster than a conversion pass stops output with an error.
// RULE_23: Busy flag holds from start command until the operation stops.
// RULE_24: Waiting flag holds while awaiting a start edge, at every repetition too.
// RULE_25: External inputs are synchronised before edge detection, one pulse per edge.
module dos_top #(
  parameter int DEPTH_W = 8
) (
  input  wire logic              clk_sys_in,
  input  wire logic              srst_in,
  input  wire logic              wb_cyc_in,
  input  wire logic              wb_stb_in,
  input  wire logic              wb_we_in,
  input  wire logic [7:0]        wb_adr_in,
  input  wire logic [3:0]        wb_sel_in,
  input  wire logic [31:0]       wb_dat_in,
  output      logic [31:0]       wb_dat_out,
  output      logic              wb_ack_out,
  input  wire logic              ext_clk_in,
  input  wire logic              ext_trg_in,
  output      dos_pkg::dos_dac_t dac_out,
  output      logic              settle_busy_out
);

  localparam int LW = DEPTH_W + 1;
  localparam logic [LW-1:0] LVL_FULL = LW'(2 ** DEPTH_W);
  localparam logic [7:0] SET_LAST = 8'(dos_pkg::SETTLE_CYC - 1);

  // ****************************************
  // Declarations
  // ****************************************
  dos_pkg::dos_ctrl_t  ctrl_q, ctrl_d;
  dos_pkg::dos_stat_t  stk_q, stk_d, set_v, clr_v;
  dos_pkg::dos_state_t st_q, st_d;
  dos_pkg::dos_dac_t   dac_q, dac_d;
  logic [15:0]         stopn_q, stopn_d, repn_q, repn_d, divr_q, divr_d;
  logic [15:0]         div_q, div_d, scnt_q, scnt_d, rcnt_q, rcnt_d;
  logic [15:0]         ctrl_w;
  logic [31:0]         rdat_q, rdat_d;
  logic                ack_q, ack_d, conv_q, conv_d, busy_q, busy_d;
  logic [dos_pkg::CH_W-1:0] ch_q, ch_d, lastch_q, lastch_d;
  logic [7:0]          set_q, set_d, gap_q, gap_d;
  logic [DEPTH_W-1:0]  wp_q, wp_d, rp_q, rp_d, pos_q, pos_d, raddr;
  logic [LW-1:0]       lvl_q, lvl_d;
  logic [2:0]          ck_q, ck_d, tg_q, tg_d;
  logic [15:0]         mem [2 ** DEPTH_W];
  logic wb_req, wr_go, cmd_wr, cmd_start, cmd_stop, cmd_clrst, cmd_clrmem, push_req;
  logic ck_rise, tg_rise, tg_fall, start_edge, stop_edge;
  logic tick, term, rend, pop, wr_ok;

  // Merge a 16-bit write by byte lanes.
  function automatic logic [15:0] m16(input logic [15:0] o, input logic [15:0] n,
                                      input logic [1:0] s);
    m16 = {s[1] ? n[15:8] : o[15:8], s[0] ? n[7:0] : o[7:0]};
  endfunction

  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (srst_in);

  // ****************************************
  // Wishbone slave
  // ****************************************
  // Writes take effect at the edge where the master sees ack, so a held
  // request never writes twice.
  assign wb_req     = wb_cyc_in & wb_stb_in;
  assign wr_go      = wb_req & wb_we_in & ack_q;
  assign cmd_wr     = wr_go && wb_adr_in == dos_pkg::ADR_CMD && wb_sel_in[0];
  assign cmd_start  = cmd_wr && wb_dat_in[dos_pkg::CMD_START];
  assign cmd_stop   = cmd_wr && wb_dat_in[dos_pkg::CMD_STOP];
  assign cmd_clrst  = cmd_wr && wb_dat_in[dos_pkg::CMD_CLRST];
  assign cmd_clrmem = cmd_wr && wb_dat_in[dos_pkg::CMD_CLRMEM];
  assign push_req   = wr_go && wb_adr_in == dos_pkg::ADR_DATA && (&wb_sel_in[1:0]);
  assign clr_v      = (wr_go && wb_adr_in == dos_pkg::ADR_STAT && (&wb_sel_in[1:0]))
                    ? dos_pkg::dos_stat_t'(wb_dat_in[dos_pkg::STAT_W-1:0]) : '0;

  // Configuration is frozen while an operation runs; range needs no field. [RULE_05]
  always_comb begin
    ctrl_w  = m16({6'h00, ctrl_q}, wb_dat_in[15:0], wb_sel_in[1:0]);
    ctrl_d  = ctrl_q;
    stopn_d = stopn_q;
    repn_d  = repn_q;
    divr_d  = divr_q;
    ack_d   = wb_req & ~ack_q;
    rdat_d  = rdat_q;
    if (wr_go && st_q == dos_pkg::S_IDLE) begin
      case (wb_adr_in)
        dos_pkg::ADR_CTRL:  ctrl_d  = dos_pkg::dos_ctrl_t'(ctrl_w[9:0]); // [RULE_14] [RULE_09]
        dos_pkg::ADR_STOPN: stopn_d = m16(stopn_q, wb_dat_in[15:0], wb_sel_in[1:0]);
        dos_pkg::ADR_REPN:  repn_d  = m16(repn_q, wb_dat_in[15:0], wb_sel_in[1:0]);
        dos_pkg::ADR_DIV:   divr_d  = m16(divr_q, wb_dat_in[15:0], wb_sel_in[1:0]);
        default: ;
      endcase
    end
    if (ack_d) begin
      case (wb_adr_in)
        dos_pkg::ADR_CTRL:  rdat_d = 32'(ctrl_q);
        dos_pkg::ADR_STAT:  rdat_d = 32'({lvl_q, 5'h00, stk_q});
        dos_pkg::ADR_STOPN: rdat_d = 32'(stopn_q);
        dos_pkg::ADR_REPN:  rdat_d = 32'(repn_q);
        dos_pkg::ADR_DIV:   rdat_d = 32'(divr_q);
        dos_pkg::ADR_SCNT:  rdat_d = 32'(scnt_q); // [RULE_08]
        dos_pkg::ADR_RCNT:  rdat_d = 32'(rcnt_q);
        default:            rdat_d = 32'h0000_0000;
      endcase
    end
  end

  // Register the bus side.
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      ctrl_q  <= dos_pkg::CTRL_RST;
      stopn_q <= dos_pkg::STOPN_RST;
      repn_q  <= dos_pkg::REPN_RST;
      divr_q  <= dos_pkg::DIV_RST;
      ack_q   <= 1'b0;
      rdat_q  <= 32'h0000_0000;
    end else begin
      ctrl_q  <= ctrl_d;
      stopn_q <= stopn_d;
      repn_q  <= repn_d;
      divr_q  <= divr_d;
      ack_q   <= ack_d;
      rdat_q  <= rdat_d;
    end
  end

  assign wb_ack_out = ack_q;
  assign wb_dat_out = rdat_q;

  // ****************************************
  // Input edges
  // ****************************************
  // Stage 0 feeds only stage 1; edges are taken between stages 1 and 2. [RULE_25]
  assign ck_rise    = ck_q[1] & ~ck_q[2];
  assign tg_rise    = tg_q[1] & ~tg_q[2];
  assign tg_fall    = ~tg_q[1] & tg_q[2];
  assign start_edge = ctrl_q.start_fall ? tg_fall : tg_rise;
  assign stop_edge  = ctrl_q.stop_fall ? tg_fall : tg_rise;
  // Ring replay reads relative to the oldest entry without consuming it.
  assign raddr      = rp_q + pos_q;

  // ****************************************
  // Sequencer and buffer
  // ****************************************
  // One pass converts channels 0..nch_m1, each held for the settling time.
  always_comb begin
    st_d   = st_q;
    conv_d = conv_q;
    ch_d   = ch_q;
    set_d  = set_q;
    scnt_d = scnt_q;
    rcnt_d = rcnt_q;
    pos_d  = pos_q;
    wp_d   = wp_q;
    rp_d   = rp_q;
    dac_d  = dac_q;
    dac_d.load = 1'b0;
    set_v  = '0;
    tick   = 1'b0;
    term   = 1'b0;
    rend   = 1'b0;
    pop    = 1'b0;
    wr_ok  = 1'b0;
    ck_d   = {ck_q[1:0], ext_clk_in};
    tg_d   = {tg_q[1:0], ext_trg_in};
    div_d  = (st_q != dos_pkg::S_RUN || div_q == 16'h0000) ? divr_q - 16'h0001
                                                            : div_q - 16'h0001;
    if (ctrl_q.clocked && st_q == dos_pkg::S_RUN) begin
      tick = ctrl_q.clk_ext ? ck_rise : (div_q == 16'h0000); // [RULE_09] [RULE_10]
    end
    // Buffer writes: ring contents are locked while running. [RULE_13]
    if (push_req && !(ctrl_q.ring && st_q != dos_pkg::S_IDLE)) begin
      if (lvl_q == LVL_FULL) begin
        set_v.ovf = 1'b1; // [RULE_12]
      end else begin
        wr_ok = 1'b1; // [RULE_11]
        wp_d  = wp_q + 1'b1;
      end
    end
    // Start a pass, or flag a clock that outruns the pass. [RULE_07] [RULE_22]
    if (st_q == dos_pkg::S_RUN && !conv_q && (!ctrl_q.clocked || tick)) begin
      conv_d = 1'b1;
      ch_d   = '0;
      set_d  = 8'h00;
    end else if (tick && conv_q) begin
      set_v.clk_err   = 1'b1;
      set_v.ev_clkerr = 1'b1;
      term = 1'b1;
    end
    if (conv_q) begin
      if (set_q == 8'h00) begin
        if (lvl_q == '0) begin
          set_v.urun = 1'b1;
          term = 1'b1;
        end else begin
          dac_d.code = mem[raddr]; // [RULE_03] [RULE_04]
          dac_d.ch   = ch_q;
          dac_d.load = 1'b1;
          if (ctrl_q.ring) begin
            pos_d = ({1'b0, pos_q} + 1'b1 == lvl_q) ? '0 : pos_q + 1'b1; // [RULE_13]
          end else begin
            pop  = 1'b1; // [RULE_11]
            rp_d = rp_q + 1'b1;
          end
        end
      end
      if (set_q == SET_LAST) begin
        set_d = 8'h00; // [RULE_02]
        if (ch_q == ctrl_q.nch_m1) begin
          conv_d = 1'b0;
          scnt_d = scnt_q + 16'h0001; // [RULE_08]
          if (!ctrl_q.clocked) begin
            term = 1'b1; // [RULE_01]
          end else if (!ctrl_q.stop_ext && scnt_q + 16'h0001 == stopn_q) begin
            set_v.cnt_done = 1'b1; // [RULE_21]
            set_v.ev_cnt   = 1'b1;
            rend = 1'b1; // [RULE_16]
          end
        end else begin
          ch_d = ch_q + 1'b1; // [RULE_06]
        end
      end else begin
        set_d = set_q + 8'h01;
      end
    end
    // The stop trigger is only looked at once sampling runs. [RULE_17]
    if (st_q == dos_pkg::S_RUN && ctrl_q.clocked && ctrl_q.stop_ext && stop_edge) begin
      rend = 1'b1;
    end
    // End of one run: repeat in ring mode or finish. [RULE_19] [RULE_20]
    if (rend) begin
      if (ctrl_q.ring && (ctrl_q.rep_inf || repn_q > 16'h0001)) begin
        set_v.ev_stop = 1'b1;
      end
      if (ctrl_q.ring && (ctrl_q.rep_inf || rcnt_q + 16'h0001 < repn_q)) begin
        rcnt_d = rcnt_q + 16'h0001;
        scnt_d = 16'h0000;
        pos_d  = '0;
        conv_d = 1'b0;
        st_d   = ctrl_q.start_ext ? dos_pkg::S_WAIT : dos_pkg::S_RUN; // [RULE_24]
      end else begin
        term = 1'b1;
      end
    end
    if (st_q == dos_pkg::S_WAIT && start_edge) begin
      st_d = dos_pkg::S_RUN; // [RULE_15]
      set_v.ev_start = 1'b1; // [RULE_20]
    end
    if (cmd_start && st_q == dos_pkg::S_IDLE) begin
      st_d   = (ctrl_q.clocked && ctrl_q.start_ext) ? dos_pkg::S_WAIT : dos_pkg::S_RUN;
      scnt_d = 16'h0000;
      rcnt_d = 16'h0000;
      pos_d  = '0;
      conv_d = 1'b0;
    end
    if (cmd_stop && st_q != dos_pkg::S_IDLE) begin
      term = 1'b1;
    end
    // Errors and stop commands override every stop condition. [RULE_18]
    if (term) begin
      st_d   = dos_pkg::S_IDLE;
      conv_d = 1'b0;
      set_v.ev_end = 1'b1; // [RULE_20]
    end
    lvl_d = lvl_q + LW'(wr_ok) - LW'(pop);
    if (cmd_clrmem) begin
      wp_d   = '0;
      rp_d   = '0;
      lvl_d  = '0;
      pos_d  = '0;
      scnt_d = 16'h0000;
      rcnt_d = 16'h0000;
    end
    // Sticky bits: a set in the clearing cycle wins.
    stk_d = (stk_q & ~clr_v) | set_v;
    if (cmd_clrst) begin
      stk_d.clk_err = set_v.clk_err;
      stk_d.urun    = set_v.urun;
      stk_d.ovf     = set_v.ovf;
    end
    if (cmd_clrmem) begin
      stk_d.cnt_done = set_v.cnt_done;
    end
    stk_d.busy     = st_d != dos_pkg::S_IDLE; // [RULE_23]
    stk_d.wait_trg = st_d == dos_pkg::S_WAIT; // [RULE_24]
    busy_d   = conv_d;
    lastch_d = dac_q.load ? dac_q.ch : lastch_q;
    gap_d    = dac_q.load ? 8'h00 : (gap_q == 8'hff ? gap_q : gap_q + 8'h01);
  end

  // The buffer array has no reset; its pointers do.
  always_ff @(posedge clk_sys_in) begin
    if (wr_ok) begin
      mem[wp_q] <= wb_dat_in[15:0];
    end
  end

  // Register the sequencer state.
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      st_q     <= dos_pkg::S_IDLE;
      conv_q   <= 1'b0;
      ch_q     <= '0;
      set_q    <= 8'h00;
      div_q    <= 16'h0000;
      scnt_q   <= 16'h0000;
      rcnt_q   <= 16'h0000;
      pos_q    <= '0;
      wp_q     <= '0;
      rp_q     <= '0;
      lvl_q    <= '0;
      dac_q    <= '0;
      busy_q   <= 1'b0;
      stk_q    <= '0;
      ck_q     <= 3'h0;
      tg_q     <= 3'h0;
      lastch_q <= '0;
      gap_q    <= 8'hff;
    end else begin
      st_q     <= st_d;
      conv_q   <= conv_d;
      ch_q     <= ch_d;
      set_q    <= set_d;
      div_q    <= div_d;
      scnt_q   <= scnt_d;
      rcnt_q   <= rcnt_d;
      pos_q    <= pos_d;
      wp_q     <= wp_d;
      rp_q     <= rp_d;
      lvl_q    <= lvl_d;
      dac_q    <= dac_d;
      busy_q   <= busy_d;
      stk_q    <= stk_d;
      ck_q     <= ck_d;
      tg_q     <= tg_d;
      lastch_q <= lastch_d;
      gap_q    <= gap_d;
    end
  end

  assign dac_out         = dac_q;
  assign settle_busy_out = busy_q;

  // ****************************************
  // Checks
  // ****************************************
  sequence simple_go_s;
    cmd_start && st_q == dos_pkg::S_IDLE && !ctrl_q.clocked;
  endsequence
  sequence leave_s;
    st_q != dos_pkg::S_IDLE ##1 st_q == dos_pkg::S_IDLE;
  endsequence

  simple_end_a: assert property (simple_go_s |-> ##[1:300] st_q == dos_pkg::S_IDLE) // [RULE_01]
    else $error("simple pass did not end");
  settle_gap_a: assert property (dac_q.load |-> gap_q >= SET_LAST) // [RULE_02]
    else $error("load came before settling ended");
  chan_order_a: assert property (dac_q.load && dac_q.ch != '0 |-> // [RULE_06]
    dac_q.ch == lastch_q + 1'b1)
    else $error("channel order broken");
  pace_go_a: assert property (tick && !conv_q && !term && !rend |=> conv_q) // [RULE_07]
    else $error("sampling clock did not start a pass");
  clk_err_a: assert property (tick && conv_q |=> // [RULE_22]
    st_q == dos_pkg::S_IDLE && stk_q.clk_err && stk_q.ev_clkerr)
    else $error("clock error not handled");
  ovf_flag_a: assert property (push_req && lvl_q == LVL_FULL && !ctrl_q.ring // [RULE_12]
    |=> stk_q.ovf)
    else $error("overflow not flagged");
  ring_lock_a: assert property (push_req && ctrl_q.ring && st_q != dos_pkg::S_IDLE // [RULE_13]
    |=> wp_q == $past(wp_q))
    else $error("ring write accepted while running");
  cnt_stop_a: assert property (set_v.ev_cnt && !ctrl_q.ring |=> // [RULE_16]
    st_q == dos_pkg::S_IDLE && scnt_q == stopn_q)
    else $error("count stop missed");
  err_stop_a: assert property (set_v.urun || set_v.clk_err |=> st_q == dos_pkg::S_IDLE) // [RULE_18]
    else $error("error did not stop sampling");
  trig_start_a: assert property (st_q == dos_pkg::S_WAIT && start_edge && !cmd_stop // [RULE_15]
    |=> st_q == dos_pkg::S_RUN && stk_q.ev_start && !stk_q.wait_trg)
    else $error("trigger start not taken");
  end_ev_a: assert property (leave_s |-> stk_q.ev_end) // [RULE_20]
    else $error("end event missing");
  busy_set_a: assert property (cmd_start && st_q == dos_pkg::S_IDLE |=> stk_q.busy) // [RULE_23]
    else $error("busy not set at start");
  sync_once_a: assert property (ck_rise |=> !ck_rise) // [RULE_25]
    else $error("one edge gave two pulses");

endmodule

// >>> core/dos_pkg.sv
package dos_pkg;

  // ****************************************
  // Register map, byte addresses on the bus
  // ****************************************
  localparam logic [7:0] ADR_CTRL  = 8'h00;
  localparam logic [7:0] ADR_CMD   = 8'h04;
  localparam logic [7:0] ADR_STAT  = 8'h08;
  localparam logic [7:0] ADR_DATA  = 8'h0c;
  localparam logic [7:0] ADR_STOPN = 8'h10;
  localparam logic [7:0] ADR_REPN  = 8'h14;
  localparam logic [7:0] ADR_DIV   = 8'h18;
  localparam logic [7:0] ADR_SCNT  = 8'h1c;
  localparam logic [7:0] ADR_RCNT  = 8'h20;

  // Bit positions in the command register.
  localparam int CMD_START  = 0;
  localparam int CMD_STOP   = 1;
  localparam int CMD_CLRST  = 2;
  localparam int CMD_CLRMEM = 3;

  // ****************************************
  // Widths, timing and reset values
  // ****************************************
  localparam int CH_W       = 2;
  localparam int CODE_W     = 16;
  localparam int STAT_W     = 11;
  localparam int CLK_NS     = 10;
  localparam int SETTLE_NS  = 500;
  // Least time, so the cycle count rounds up.
  localparam int SETTLE_CYC = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [15:0] DIV_RST   = 16'h0064;
  localparam logic [15:0] STOPN_RST = 16'h0001;
  localparam logic [15:0] REPN_RST  = 16'h0001;

  // Control register fields, low bits first from the right.
  typedef struct packed {
    logic            rep_inf;
    logic            stop_fall;
    logic            stop_ext;
    logic            start_fall;
    logic            start_ext;
    logic            clk_ext;
    logic            ring;
    logic            clocked;
    logic [CH_W-1:0] nch_m1;
  } dos_ctrl_t;
  localparam dos_ctrl_t CTRL_RST = '0;

  // Status register fields; busy and wait_trg are live, the rest sticky.
  typedef struct packed {
    logic ev_clkerr;
    logic ev_cnt;
    logic ev_end;
    logic ev_stop;
    logic ev_start;
    logic urun;
    logic ovf;
    logic clk_err;
    logic cnt_done;
    logic wait_trg;
    logic busy;
  } dos_stat_t;

  typedef enum logic [2:0] {
    S_IDLE = 3'b001,
    S_WAIT = 3'b010,
    S_RUN  = 3'b100
  } dos_state_t;

  // One converter load: channel, code and a one-cycle load strobe.
  typedef struct packed {
    logic [CH_W-1:0]   ch;
    logic [CODE_W-1:0] code;
    logic              load;
  } dos_dac_t;

endpackage

// >>> verif/dos_far_model.sv
`timescale 1ns/1ps
// ****************************************
// Far side: converter channels and isolated control inputs
// ****************************************
module dos_far_model (
  input  wire logic              clk_in,
  input  wire dos_pkg::dos_dac_t dac_in,
  input  wire logic              settle_busy_in,
  output      logic              ext_clk_out,
  output      logic              ext_trg_out
);
  logic [17:0] ld_q[$];
  int          tm_q[$];
  int          cyc_cnt;
  int          n_busy_bad;

  // Both control lines idle low; the clock only moves while traffic is wanted.
  initial begin
    ext_clk_out = 1'b0;
    ext_trg_out = 1'b0;
    cyc_cnt     = 0;
    n_busy_bad  = 0;
  end

  // Each load latches a code unchanged; the stamp lets the bench see the pace.
  always @(posedge clk_in) begin
    cyc_cnt <= cyc_cnt + 1;
    if (dac_in.load === 1'b1) begin
      ld_q.push_back({dac_in.ch, dac_in.code});
      tm_q.push_back(cyc_cnt);
      // A code that lands while the settling line is down would be missed outside.
      if (settle_busy_in !== 1'b1) n_busy_bad <= n_busy_bad + 1;
    end
  end

  // One clean digital pulse on the clock line or on the trigger line.
  task automatic pulse(input logic trg, input int hi);
    @(posedge clk_in);
    if (trg) ext_trg_out <= 1'b1;
    else ext_clk_out <= 1'b1;
    repeat (hi) @(posedge clk_in);
    if (trg) ext_trg_out <= 1'b0;
    else ext_clk_out <= 1'b0;
  endtask
endmodule

// >>> verif/tb.sv
`timescale 1ns/1ps
module tb;
  typedef struct {logic [7:0] adr; logic [31:0] wd; logic [31:0] ex;} dos_row_t;
  logic              clk_sys_in;
  logic              srst_in;
  logic              wb_cyc_in;
  logic              wb_stb_in;
  logic              wb_we_in;
  logic [7:0]        wb_adr_in;
  logic [3:0]        wb_sel_in;
  logic [31:0]       wb_dat_in;
  logic [31:0]       wb_dat_out;
  logic              wb_ack_out;
  logic              ext_clk_in;
  logic              ext_trg_in;
  dos_pkg::dos_dac_t dac_out;
  logic              settle_busy_out;
  logic [31:0]       rd;
  int                n_errors;
  int                checks_done;
  int                t0;
  int                t1;
  dos_row_t          rows[6] = '{'{8'h00, 32'h0155, 32'h0155}, '{8'h00, 32'h02aa, 32'h02aa},
    '{8'h10, 32'hffff, 32'hffff}, '{8'h14, 32'h0000, 32'h0000},
    '{8'h18, 32'h0001, 32'h0001}, '{8'h3c, 32'h1234, 32'h0000}};

  // 100 MHz system clock.
  always #5 clk_sys_in = ~clk_sys_in;

  // A small buffer so that filling it to the brim stays cheap.
  dos_top #(.DEPTH_W(4)) DUT (.clk_sys_in(clk_sys_in), .srst_in(srst_in),
    .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in),
    .wb_adr_in(wb_adr_in), .wb_sel_in(wb_sel_in), .wb_dat_in(wb_dat_in),
    .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out), .ext_clk_in(ext_clk_in),
    .ext_trg_in(ext_trg_in), .dac_out(dac_out), .settle_busy_out(settle_busy_out));
  dos_far_model u_far (.clk_in(clk_sys_in), .dac_in(dac_out),
    .settle_busy_in(settle_busy_out), .ext_clk_out(ext_clk_in), .ext_trg_out(ext_trg_in));

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic end_sim();
    if (n_errors == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] ex);
    checks_done++;
    if (got !== ex) begin
      n_errors++;
      $display("Error at %0t: got %h, expected %h", $time, got, ex);
    end
  endtask

  // Classic cycle: hold everything until ack is sampled, then release.
  task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys_in);
    wb_cyc_in <= 1'b1;
    wb_stb_in <= 1'b1;
    wb_we_in  <= we;
    wb_adr_in <= a;
    wb_dat_in <= d;
    do begin
      @(posedge clk_sys_in);
    end while (wb_ack_out !== 1'b1);
    rd = wb_dat_out;
    wb_cyc_in <= 1'b0;
    wb_stb_in <= 1'b0;
    chk({31'h0, wb_ack_out}, 32'h1);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] ex);
    bus(1'b0, a, 32'h0);
    chk(rd, ex);
  endtask

  // Polls busy under a bound; a hang shows up as a mismatch.
  task automatic wait_idle();
    int n;
    n = 0;
    do begin
      bus(1'b0, dos_pkg::ADR_STAT, 32'h0);
      n++;
    end while (rd[0] !== 1'b0 && n < 400);
    chk({31'h0, rd[0]}, 32'h0);
  endtask

  task automatic pop(input logic [1:0] ch, input logic [15:0] code);
    chk({31'h0, u_far.ld_q.size() > 0}, 32'h1);
    if (u_far.ld_q.size() > 0) begin
      chk({14'h0, u_far.ld_q.pop_front()}, {14'h0, ch, code});
      t0 = t1;
      t1 = u_far.tm_q.pop_front();
    end
  endtask

  task automatic clr();
    bus(1'b1, dos_pkg::ADR_CMD, 32'h000c);
    bus(1'b1, dos_pkg::ADR_STAT, 32'h07ff);
    u_far.ld_q.delete();
    u_far.tm_q.delete();
  endtask

  // Clocks up to four sampling edges, spaced wider than one pass, until n loads.
  task automatic ext_ticks(input int n);
    repeat (4) if (u_far.ld_q.size() < n) begin
      u_far.pulse(1'b0, 3);
      repeat (70) @(posedge clk_sys_in);
    end
  endtask

  // Watchdog, far beyond the few thousand cycles the sequence needs.
  initial begin
    repeat (20000) @(posedge clk_sys_in);
    n_errors++;
    end_sim();
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    clk_sys_in = 1'b0;
    srst_in = 1'b1;
    wb_cyc_in = 1'b0;
    wb_stb_in = 1'b0;
    wb_we_in = 1'b0;
    wb_adr_in = 8'h00;
    wb_sel_in = 4'hf;
    wb_dat_in = 32'h0;
    n_errors = 0;
    checks_done = 0;
    repeat (4) @(posedge clk_sys_in);
    srst_in <= 1'b0;
    foreach (rows[i]) begin
      bus(1'b1, rows[i].adr, rows[i].wd);
      rd_chk(rows[i].adr, rows[i].ex);
    end
    srst_in <= 1'b1;
    repeat (4) @(posedge clk_sys_in);
    srst_in <= 1'b0;
    rd_chk(8'h00, 32'h0);
    rd_chk(8'h10, 32'h1);
    rd_chk(8'h14, 32'h1);
    rd_chk(8'h18, 32'h64);
    rd_chk(8'h08, 32'h0);
    // Simple mode, two channels, boundary codes, one spare word left behind.
    bus(1'b1, 8'h00, 32'h1);
    bus(1'b1, 8'h0c, 32'h8000);
    bus(1'b1, 8'h0c, 32'hffff);
    bus(1'b1, 8'h0c, 32'h0000);
    bus(1'b1, 8'h04, 32'h1);
    bus(1'b0, 8'h08, 32'h0);
    chk({31'h0, rd[0]}, 32'h1);
    wait_idle();
    pop(2'd0, 16'h8000);
    pop(2'd1, 16'hffff);
    chk({31'h0, t1 - t0 >= dos_pkg::SETTLE_CYC}, 32'h1);
    chk(u_far.ld_q.size(), 32'h0);
    chk({31'h0, settle_busy_out}, 32'h0);
    bus(1'b0, 8'h08, 32'h0);
    chk(32'({rd[24:16], rd[10:0]}), 32'({9'd1, 11'h100}));
    clr();
    // Clocked FIFO, internal clock, count stop at three.
    bus(1'b1, 8'h18, 32'd80);
    bus(1'b1, 8'h10, 32'd3);
    bus(1'b1, 8'h00, 32'h4);
    for (int i = 1; i < 5; i++) bus(1'b1, 8'h0c, 32'(i));
    bus(1'b1, 8'h04, 32'h1);
    wait_idle();
    pop(2'd0, 16'd1);
    pop(2'd0, 16'd2);
    chk(32'(t1 - t0), 32'd80);
    pop(2'd0, 16'd3);
    chk(u_far.ld_q.size(), 32'h0);
    rd_chk(8'h1c, 32'd3);
    bus(1'b0, 8'h08, 32'h0);
    chk(32'({rd[24:16], rd[10:0]}), 32'({9'd1, 11'h304}));
    clr();
    // Sampling period shorter than a pass.
    bus(1'b1, 8'h18, 32'd10);
    bus(1'b1, 8'h10, 32'd5);
    for (int i = 0; i < 5; i++) bus(1'b1, 8'h0c, 32'(i));
    bus(1'b1, 8'h04, 32'h1);
    wait_idle();
    chk(u_far.ld_q.size(), 32'h1);
    bus(1'b0, 8'h08, 32'h0);
    chk({21'h0, rd[10:0]}, 32'h508);
    clr();
    // Full buffer, run started, two more writes: the second one overflows.
    bus(1'b1, 8'h18, 32'd80);
    bus(1'b1, 8'h10, 32'd2);
    for (int i = 0; i < 16; i++) bus(1'b1, 8'h0c, 32'(i));
    bus(1'b1, 8'h04, 32'h1);
    repeat (100) @(posedge clk_sys_in);
    bus(1'b1, 8'h0c, 32'h77);
    bus(1'b1, 8'h0c, 32'h78);
    wait_idle();
    pop(2'd0, 16'd0);
    pop(2'd0, 16'd1);
    bus(1'b0, 8'h08, 32'h0);
    chk(32'({rd[24:16], rd[10:0]}), 32'({9'd15, 11'h314}));
    clr();
    // Trigger stop on the falling edge: the rise is ignored, one pass gets out.
    bus(1'b1, 8'h00, 32'h184);
    for (int i = 0; i < 3; i++) bus(1'b1, 8'h0c, 32'(i));
    bus(1'b1, 8'h04, 32'h1);
    u_far.pulse(1'b1, 100);
    wait_idle();
    chk(u_far.ld_q.size(), 32'h1);
    bus(1'b0, 8'h08, 32'h0);
    chk(32'({rd[24:16], rd[10:0]}), 32'({9'd2, 11'h100}));
    clr();
    // Ring, external clock, rising start trigger, two repetitions.
    bus(1'b1, 8'h14, 32'd2);
    bus(1'b1, 8'h00, 32'h3c);
    bus(1'b1, 8'h0c, 32'haaaa);
    bus(1'b1, 8'h0c, 32'h5555);
    bus(1'b1, 8'h04, 32'h1);
    bus(1'b0, 8'h08, 32'h0);
    chk({30'h0, rd[1:0]}, 32'h3);
    bus(1'b1, 8'h0c, 32'h1111);
    bus(1'b0, 8'h08, 32'h0);
    chk({23'h0, rd[24:16]}, 32'd2);
    for (int r = 0; r < 2; r++) begin
      u_far.pulse(1'b1, 3);
      repeat (10) @(posedge clk_sys_in);
      bus(1'b0, 8'h08, 32'h0);
      chk({30'h0, rd[1:0]}, 32'h1);
      ext_ticks(2);
      pop(2'd0, 16'haaaa);
      pop(2'd0, 16'h5555);
      bus(1'b0, 8'h08, 32'h0);
      chk({31'h0, rd[1]}, 32'(r == 0));
    end
    wait_idle();
    bus(1'b0, 8'h08, 32'h0);
    chk({21'h0, rd[10:0]}, 32'h3c4);
    clr();
    // Endless ring repetition ends only by the stop command.
    bus(1'b1, 8'h10, 32'd1);
    bus(1'b1, 8'h00, 32'h20c);
    bus(1'b1, 8'h0c, 32'h0042);
    bus(1'b1, 8'h04, 32'h1);
    repeat (300) @(posedge clk_sys_in);
    bus(1'b0, 8'h08, 32'h0);
    chk({31'h0, rd[0]}, 32'h1);
    bus(1'b1, 8'h04, 32'h2);
    wait_idle();
    chk(u_far.n_busy_bad, 32'h0);
    end_sim();
  end
endmodule
